// [gserdes_pkg.sv]
// Constants, types and helpers shared by the serial transceiver datapath
package gserdes_pkg;

  // ---------------------------------------------------------------
  // Word geometry and clocking
  // ---------------------------------------------------------------
  localparam int WORD_BITS = 10;
  localparam int HALF_BITS = 5;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'h9;
  localparam int CLK_PERIOD_NS = 10;

  // ---------------------------------------------------------------
  // Power-on reset hold time
  // ---------------------------------------------------------------
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES =
    (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_W = 8;
  localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);

  // ---------------------------------------------------------------
  // Transmit and receive phase points
  // ---------------------------------------------------------------
  // Word counter value at which the serializer loads; sets latency
  localparam logic [CNT_W-1:0] TX_LOAD_CNT = 4'h6;
  // Receive phase of the mid-word point (DDR falling, half-rate update)
  localparam logic [CNT_W-1:0] RX_MID_PH = 4'h5;
  localparam logic [CNT_W-1:0] RX_FIRST_PH = 4'h0;

  localparam logic [WORD_BITS-1:0] WORD_RESET = 10'h000;
  localparam logic [HALF_BITS-1:0] HALF_RESET = 5'h00;

  typedef enum logic {MODE_TEN_BIT, MODE_DDR} width_mode_e;

  // Modulo-ten step of a bit or phase counter
  function automatic logic [CNT_W-1:0] wrap_inc(input logic [CNT_W-1:0] v);
    logic [CNT_W-1:0] r;
    r = (v == LAST_BIT) ? 4'h0 : CNT_W'(v + 4'h1);
    return r;
  endfunction

endpackage

// [rx_word_retimer.sv]
// Receive retimer and deserializer producing aligned 10-bit words
`timescale 1ns/10ps
`default_nettype none
module rx_word_retimer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic serial_in_i,
  output logic [gserdes_pkg::WORD_BITS-1:0] word_o,
  output logic word_strobe_o
);
  import gserdes_pkg::*;

  typedef struct packed {
    logic meta;
    logic sampled;
    logic [WORD_BITS-1:0] shift;
    logic [CNT_W-1:0] cnt;
    logic [WORD_BITS-1:0] word;
    logic strobe;
  } rx_state_s;

  rx_state_s state_ff;
  rx_state_s nxt_state;

  // ---------------------------------------------------------------
  // Retime and deserialize
  // ---------------------------------------------------------------
  // The sampling point is the local bit clock, which runs from the
  // reference; incoming rate must match it within the link tolerance.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.meta = serial_in_i;
    nxt_state.sampled = state_ff.meta;
    // Bit 0 arrives first, so bits enter at the top and move down
    nxt_state.shift = {state_ff.sampled, state_ff.shift[WORD_BITS-1:1]};
    // Free-running counter: no lock request is ever needed
    nxt_state.cnt = wrap_inc(state_ff.cnt);
    nxt_state.strobe = 1'b0;
    if (state_ff.cnt == LAST_BIT) begin
      nxt_state.word = {state_ff.sampled, state_ff.shift[WORD_BITS-1:1]};
      nxt_state.strobe = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign word_o = state_ff.word;
  assign word_strobe_o = state_ff.strobe;

endmodule
`default_nettype wire

// [gigabit_serdes_parallel_path.sv]
// Parallel-side transmit and receive datapath of the serial transceiver
`timescale 1ns/10ps
`default_nettype none
module gigabit_serdes_parallel_path (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reference_clock_in_i,
  input wire logic parallel_width_select_i,
  input wire logic rx_clock_rate_select_i,
  input wire logic [gserdes_pkg::WORD_BITS-1:0] tx_parallel_word_i,
  input wire logic serial_in_i,
  output logic serial_out_pos_o,
  output logic serial_out_neg_o,
  output logic serial_out_oe_o,
  output logic [gserdes_pkg::WORD_BITS-1:0] rx_parallel_word_o,
  output logic rx_byte_clock_a_o,
  output logic rx_byte_clock_b_o
);
  import gserdes_pkg::*;

  typedef struct packed {
    // Pin synchronisers: the meta stages feed only the next stage
    logic ref_meta;
    logic ref_sync;
    logic ref_prev;
    logic width_meta;
    logic width_sync;
    logic rate_meta;
    logic rate_sync;
    logic [WORD_BITS-1:0] td_meta;
    logic [WORD_BITS-1:0] td_sync;
    // Power-on reset
    logic [POR_W-1:0] por_cnt;
    logic por_done;
    // Transmit path
    logic [HALF_BITS-1:0] lo_half;
    logic [WORD_BITS-1:0] tx_word;
    logic [WORD_BITS-1:0] tx_word_dly;
    logic [CNT_W-1:0] tx_cnt;
    logic [WORD_BITS-1:0] tx_shift;
    logic ser_pos;
    logic ser_neg;
    logic ser_oe;
    // Receive presentation
    logic [WORD_BITS-1:0] rx_hold;
    logic [CNT_W-1:0] rx_ph;
    logic rx_parity;
    logic [WORD_BITS-1:0] rx_out;
    logic rbc_a;
    logic rbc_b;
  } top_state_s;

  top_state_s state_ff;
  top_state_s nxt_state;

  logic [WORD_BITS-1:0] rx_word;
  logic rx_strobe;
  logic ref_rise;
  logic ref_fall;
  width_mode_e width_mode;
  logic [WORD_BITS-1:0] load_word;

  // ---------------------------------------------------------------
  // Receive retimer
  // ---------------------------------------------------------------
  rx_word_retimer u_rx (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .serial_in_i(serial_in_i),
    .word_o(rx_word),
    .word_strobe_o(rx_strobe)
  );

  // ---------------------------------------------------------------
  // Mode and reference edge decode
  // ---------------------------------------------------------------
  assign ref_rise = state_ff.ref_sync & ~state_ff.ref_prev;
  assign ref_fall = ~state_ff.ref_sync & state_ff.ref_prev;
  assign width_mode = state_ff.width_sync ? MODE_DDR : MODE_TEN_BIT;
  // DDR words wait one extra word so the falling half is complete
  assign load_word = (width_mode == MODE_DDR) ?
                     state_ff.tx_word_dly : state_ff.tx_word;

  always_comb begin
    nxt_state = state_ff;

    // -------------------------------------------------------------
    // Synchronisers
    // -------------------------------------------------------------
    nxt_state.ref_meta = reference_clock_in_i;
    nxt_state.ref_sync = state_ff.ref_meta;
    nxt_state.ref_prev = state_ff.ref_sync;
    nxt_state.width_meta = parallel_width_select_i;
    nxt_state.width_sync = state_ff.width_meta;
    nxt_state.rate_meta = rx_clock_rate_select_i;
    nxt_state.rate_sync = state_ff.rate_meta;
    nxt_state.td_meta = tx_parallel_word_i;
    nxt_state.td_sync = state_ff.td_meta;

    // -------------------------------------------------------------
    // Power-on reset
    // -------------------------------------------------------------
    if (!state_ff.por_done) begin
      if (state_ff.por_cnt == POR_LAST) begin
        nxt_state.por_done = 1'b1;
      end else begin
        nxt_state.por_cnt = POR_W'(state_ff.por_cnt + 8'h01);
      end
    end

    // -------------------------------------------------------------
    // Transmit word capture
    // -------------------------------------------------------------
    // The word counter restarts at every reference rise, so the ten
    // bit times of a word stay locked to the reference period
    nxt_state.tx_cnt = wrap_inc(state_ff.tx_cnt);
    if (ref_rise) begin
      nxt_state.tx_cnt = 4'h0;
      nxt_state.tx_word_dly = state_ff.tx_word;
      if (width_mode == MODE_TEN_BIT) begin
        nxt_state.tx_word = state_ff.td_sync;
      end else begin
        nxt_state.lo_half = state_ff.td_sync[HALF_BITS-1:0];
      end
    end
    if (ref_fall && width_mode == MODE_DDR) begin
      // Falling half completes the word begun on the preceding reference rise
      nxt_state.tx_word = {state_ff.td_sync[HALF_BITS-1:0],
                           state_ff.lo_half};
    end

    // -------------------------------------------------------------
    // Serializer
    // -------------------------------------------------------------
    // Load point fixes bit 9 at 19-20 (ten-bit) or 29-30 (DDR) bits
    // after the reference rise; the spread is pin sampling jitter
    if (state_ff.tx_cnt == TX_LOAD_CNT) begin
      nxt_state.ser_pos = load_word[0];
      nxt_state.tx_shift = {1'b0, load_word[WORD_BITS-1:1]};
    end else begin
      nxt_state.ser_pos = state_ff.tx_shift[0];
      nxt_state.tx_shift = {1'b0, state_ff.tx_shift[WORD_BITS-1:1]};
    end
    nxt_state.ser_neg = ~nxt_state.ser_pos;
    nxt_state.ser_oe = state_ff.por_done;

    // -------------------------------------------------------------
    // Receive byte clocks and data
    // -------------------------------------------------------------
    nxt_state.rx_ph = wrap_inc(state_ff.rx_ph);
    if (rx_strobe) begin
      nxt_state.rx_hold = rx_word;
      nxt_state.rx_ph = 4'h0;
      nxt_state.rx_parity = ~state_ff.rx_parity;
    end
    if (width_mode == MODE_DDR) begin
      // One full-rate clock; bits 0-4 at its rise, 5-9 at its fall
      nxt_state.rbc_a = (state_ff.rx_ph < RX_MID_PH);
      nxt_state.rbc_b = 1'b0;
      if (state_ff.rx_ph == RX_FIRST_PH) begin
        nxt_state.rx_out = {{HALF_BITS{1'b0}},
                            state_ff.rx_hold[HALF_BITS-1:0]};
      end else if (state_ff.rx_ph == RX_MID_PH) begin
        nxt_state.rx_out = {{HALF_BITS{1'b0}},
                            state_ff.rx_hold[WORD_BITS-1:HALF_BITS]};
      end
    end else if (state_ff.rate_sync) begin
      // Full rate: data launched with the rise of the first clock
      nxt_state.rbc_a = (state_ff.rx_ph < RX_MID_PH);
      nxt_state.rbc_b = 1'b0;
      if (state_ff.rx_ph == RX_FIRST_PH) begin
        nxt_state.rx_out = state_ff.rx_hold;
      end
    end else begin
      // Half rate: each clock high for one word, low for the next;
      // data changes mid-word so each rise sees it settled
      nxt_state.rbc_a = state_ff.rx_parity;
      nxt_state.rbc_b = ~state_ff.rx_parity;
      if (state_ff.rx_ph == RX_MID_PH) begin
        nxt_state.rx_out = state_ff.rx_hold;
      end
    end
    if (!state_ff.por_done) begin
      nxt_state.rbc_a = 1'b0;
      nxt_state.rbc_b = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign serial_out_pos_o = state_ff.ser_pos;
  assign serial_out_neg_o = state_ff.ser_neg;
  assign serial_out_oe_o = state_ff.ser_oe;
  assign rx_parallel_word_o = state_ff.rx_out;
  assign rx_byte_clock_a_o = state_ff.rbc_a;
  assign rx_byte_clock_b_o = state_ff.rbc_b;

endmodule
`default_nettype wire

// [gserdes_assertions.sv]
// Port-timing checker of the serial transceiver datapath
`timescale 1ns/10ps
`default_nettype none
module gserdes_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic parallel_width_select_i,
  input wire logic rx_clock_rate_select_i,
  input wire logic serial_out_pos_o,
  input wire logic serial_out_neg_o,
  input wire logic serial_out_oe_o,
  input wire logic [gserdes_pkg::WORD_BITS-1:0] rx_parallel_word_o,
  input wire logic rx_byte_clock_a_o,
  input wire logic rx_byte_clock_b_o
);
  import gserdes_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic a, b, sel, oe, ddr, full, half;
  assign a = rx_byte_clock_a_o;
  assign b = rx_byte_clock_b_o;
  assign sel = parallel_width_select_i;
  assign oe = serial_out_oe_o;
  assign ddr = sel && oe;
  assign full = !sel && rx_clock_rate_select_i && oe;
  assign half = !sel && !rx_clock_rate_select_i && oe;
  property p_oe_por; $rose(rst_n_i) |-> !oe [*8]; endproperty
  a_oe_por: assert property (p_oe_por) else $error("oe early");
  property p_clk_por; $rose(rst_n_i) |-> (!a && !b) [*8]; endproperty
  a_clk_por: assert property (p_clk_por) else $error("clk early");
  property p_oe_keep; oe |=> oe; endproperty
  a_oe_keep: assert property (p_oe_keep) else $error("oe drop");
  property p_diff; oe |-> serial_out_neg_o != serial_out_pos_o; endproperty
  a_diff: assert property (p_diff) else $error("neg not inverse");
  property p_full; (full || ddr) && $rose(a) |-> a [*5] ##1 !a [*5] ##1 a;
  endproperty
  a_full: assert property (p_full) else $error("a period");
  property p_b_low; full || ddr |-> !b; endproperty
  a_b_low: assert property (p_b_low) else $error("b not low");
  property p_half; half && $rose(a) |-> !b ##10 (!a && b); endproperty
  a_half: assert property (p_half) else $error("half phase");
  property p_half_b; half && $rose(b) |-> !a ##10 $fell(b); endproperty
  a_half_b: assert property (p_half_b) else $error("b period");
  property p_fdat; full && $changed(rx_parallel_word_o) |-> $rose(a);
  endproperty
  a_fdat: assert property (p_fdat) else $error("data off a");
  property p_ddat; ddr && $changed(rx_parallel_word_o) |-> $changed(a);
  endproperty
  a_ddat: assert property (p_ddat) else $error("ddr data");
  c_full: cover property (full && $rose(a));
  c_half: cover property (half && $rose(b));
  c_ddr: cover property (ddr && $fell(a));
endmodule
bind gigabit_serdes_parallel_path gserdes_checker gserdes_checker_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i),
  .parallel_width_select_i(parallel_width_select_i),
  .rx_clock_rate_select_i(rx_clock_rate_select_i),
  .serial_out_pos_o(serial_out_pos_o), .serial_out_neg_o(serial_out_neg_o),
  .serial_out_oe_o(serial_out_oe_o), .rx_parallel_word_o(rx_parallel_word_o),
  .rx_byte_clock_a_o(rx_byte_clock_a_o), .rx_byte_clock_b_o(rx_byte_clock_b_o));
`default_nettype wire

// [serdes_ctrl_model.sv]
// Protocol controller model driving reference clock and transmit pins
`timescale 1ns/10ps
`default_nettype none
module serdes_ctrl_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ddr_i,
  input wire logic [9:0] word_i,
  output logic ref_o,
  output logic [9:0] tx_o,
  output logic launch_o
);
  int ph;
  logic [9:0] cur;
  assign launch_o = (ph == 9);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph <= 0;
      ref_o <= 1'b0;
      tx_o <= 10'h000;
      cur <= 10'h000;
    end else begin
      ph <= (ph == 9) ? 0 : ph + 1;
      ref_o <= (ph == 9) || (ph < 4);
      if (ph == 9) begin
        cur <= word_i;
        // Unused upper pins carry a moving pattern so stray sampling shows
        tx_o <= ddr_i ? {~word_i[4:0], word_i[4:0]} : word_i;
      end else if (ph == 4 && ddr_i) begin
        tx_o <= {~cur[9:5], cur[9:5]};
      end
    end
  end
endmodule
`default_nettype wire

// [gigabit_serdes_parallel_path_tb.sv]
// Self-checking bench of the serial transceiver datapath
`timescale 1ns/10ps
`default_nettype none
module gigabit_serdes_parallel_path_tb;
  import gserdes_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sel = 1'b0;
  logic rate = 1'b1;
  logic sin = 1'b0;
  logic launch, refc, pos, neg, oe, ra, rb;
  logic [WORD_BITS-1:0] tx, rxw;
  logic [WORD_BITS-1:0] words [64];
  int idx = 0;
  int cyc = 0;
  int start = -1;
  int miscompares = 0;
  int checks = 0;
  bit q [$];
  // Serial input history by cycle, read back by the receive model
  bit hist [4096];
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  serdes_ctrl_model serdes_ctrl_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ddr_i(sel), .word_i(words[idx % 64]), .ref_o(refc), .tx_o(tx),
    .launch_o(launch));
  gigabit_serdes_parallel_path gigabit_serdes_parallel_path_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reference_clock_in_i(refc),
    .parallel_width_select_i(sel), .rx_clock_rate_select_i(rate),
    .tx_parallel_word_i(tx), .serial_in_i(sin), .serial_out_pos_o(pos),
    .serial_out_neg_o(neg), .serial_out_oe_o(oe), .rx_parallel_word_o(rxw),
    .rx_byte_clock_a_o(ra), .rx_byte_clock_b_o(rb));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Reference model: expected serial bit stream
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    cyc++;
    hist[cyc] = 1'($urandom);
    sin <= hist[cyc];
    if (cyc > 3000) begin
      miscompares++;
      end_sim();
    end
    if (rst_n_i && launch) begin
      if (q.size() == 0) start = cyc + (sel ? 20 : 10);
      for (int i = 0; i < WORD_BITS; i++) q.push_back(words[idx % 64][i]);
      idx <= idx + 1;
    end
    #1;
    if (start >= 0 && cyc >= start && q.size() > 0) begin
      bit b;
      b = q.pop_front();
      if (oe === 1'b1) begin
        check(10'(pos), 10'(b));
        check(10'(neg), 10'(!b));
      end
    end
  end
  task automatic run(input logic m, input logic r);
    int na, nb;
    logic pa, pb;
    logic [WORD_BITS-1:0] want;
    na = 0;
    nb = 0;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    sel <= m;
    rate <= r;
    repeat (4) @(posedge clk_i);
    #2;
    q.delete();
    start = -1;
    check(10'({ra, rb, oe}), 10'h000);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (90) begin
      @(posedge clk_i);
      #2;
      check(10'({ra, rb, oe}), 10'h000);
    end
    for (int i = 0; i < 60 && oe !== 1'b1; i++) @(posedge clk_i);
    // Let the edge settle so the count baseline is the post-edge value
    #2;
    check(10'(oe), 10'h001);
    pa = ra;
    pb = rb;
    repeat (200) begin
      @(posedge clk_i);
      #2;
      na += int'(ra && !pa);
      nb += int'(rb && !pb);
      // Word sits 14 bits (24 at half rate) behind each rising byte clock edge and each DDR falling edge
      if ((m && ra != pa) || (ra && !pa) || (rb && !pb)) begin
        want = '0;
        for (int i = 0; i < (m ? HALF_BITS : WORD_BITS); i++) begin
          want[i] = hist[cyc - ((m || r) ? 14 : 24) + i];
        end
        check(rxw, want);
      end
      pa = ra;
      pb = rb;
    end
    // Rate set by width and rate selects, no lock request needed
    check(10'(na), (m || r) ? 10'h014 : 10'h00a);
    check(10'(nb), (!m && !r) ? 10'h00a : 10'h000);
    $display("test mode=%0d rate=%0d done", m, r);
  endtask
  initial begin
    void'($urandom(92899));
    foreach (words[i]) words[i] = 10'($urandom);
    run(1'b0, 1'b1);
    run(1'b0, 1'b0);
    run(1'b1, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
